// file: design/stm_pkg.sv
// Constants, field layouts and carrier types of the 16-bit standard timer.
// Assumes a 32-bit classic Wishbone register bus with byte offsets.
package stm_pkg;

  // ----------------------------------------------------------------
  // Register map, byte offsets, one register per aligned word
  // ----------------------------------------------------------------
  localparam logic [7:0] STM_OFS_CLK_CTRL  = 8'h00;
  localparam logic [7:0] STM_OFS_MODE_CTRL = 8'h04;
  localparam logic [7:0] STM_OFS_COUNT_LO  = 8'h08;
  localparam logic [7:0] STM_OFS_COUNT_HI  = 8'h0C;
  localparam logic [7:0] STM_OFS_CMPA_LO   = 8'h10;
  localparam logic [7:0] STM_OFS_CMPA_HI   = 8'h14;
  localparam logic [7:0] STM_OFS_CMPP      = 8'h18;

  // ----------------------------------------------------------------
  // Reset values and masks
  // ----------------------------------------------------------------
  localparam logic [7:0]  STM_RST_BYTE      = 8'h00;
  localparam logic [15:0] STM_RST_WORD      = 16'h0000;
  localparam logic [7:0]  STM_CLK_CTRL_MASK = 8'hF8;
  localparam logic [7:0]  STM_CMPP_OVF      = 8'h00;
  localparam logic [16:0] STM_FULL_SPAN     = 17'h10000;

  // ----------------------------------------------------------------
  // Count clock sources and prescaler
  // ----------------------------------------------------------------
  localparam logic [2:0] STM_SRC_SYS_DIV4 = 3'h0;
  localparam logic [2:0] STM_SRC_SYS      = 3'h1;
  localparam logic [2:0] STM_SRC_HI_DIV16 = 3'h2;
  localparam logic [2:0] STM_SRC_HI_DIV64 = 3'h3;
  localparam logic [2:0] STM_SRC_TBC_A    = 3'h4;
  localparam logic [2:0] STM_SRC_TBC_B    = 3'h5;
  localparam logic [2:0] STM_SRC_EXT_RISE = 3'h6;
  localparam logic [2:0] STM_SRC_EXT_FALL = 3'h7;
  localparam logic [5:0] STM_DIV4_MASK    = 6'h03;
  localparam logic [5:0] STM_DIV16_MASK   = 6'h0F;
  localparam logic [5:0] STM_DIV64_MASK   = 6'h3F;

  // Synchronised pin indices
  localparam int STM_PIN_EXT = 0;
  localparam int STM_PIN_TBC = 1;
  localparam int STM_PIN_CAP = 2;

  // ----------------------------------------------------------------
  // Output function codes, per mode
  // ----------------------------------------------------------------
  localparam logic [1:0] STM_IO_NONE   = 2'h0;
  localparam logic [1:0] STM_IO_LOW    = 2'h1;
  localparam logic [1:0] STM_IO_HIGH   = 2'h2;
  localparam logic [1:0] STM_IO_TOGGLE = 2'h3;
  localparam logic [1:0] STM_IO_INACT  = 2'h0;
  localparam logic [1:0] STM_IO_ACT    = 2'h1;
  localparam logic [1:0] STM_IO_PWM    = 2'h2;
  localparam logic [1:0] STM_IO_SINGLE = 2'h3;
  localparam logic [1:0] STM_CAP_RISE  = 2'h0;
  localparam logic [1:0] STM_CAP_FALL  = 2'h1;
  localparam logic [1:0] STM_CAP_BOTH  = 2'h2;
  localparam logic [1:0] STM_CAP_OFF   = 2'h3;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    STM_MODE_COMPARE = 2'h0,
    STM_MODE_CAPTURE = 2'h1,
    STM_MODE_PWM     = 2'h2,
    STM_MODE_TIMER   = 2'h3
  } stm_mode_t;

  typedef struct packed {
    logic       pause_control;
    logic [2:0] clock_source_select;
    logic       counter_on;
    logic [2:0] unused;
  } stm_clk_ctrl_t;

  typedef struct packed {
    stm_mode_t  operating_mode_select;
    logic [1:0] output_function_select;
    logic       output_initial_level;
    logic       output_invert;
    logic       period_duty_swap;
    logic       clear_source_select;
  } stm_mode_ctrl_t;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } stm_wb_req_t;

endpackage

// file: design/stm_timer16.sv
// 16-bit standard timer: counter, comparators A and P, output pin, bus slave.
// Assumes a classic Wishbone master on i_mclk and asynchronous pins.
//
// The implementer's own choices: the placing of the registers and the Wishbone slave port.
`timescale 1ns/1ps

module stm_timer16 (
  input  wire logic               i_mclk,
  input  wire logic               i_sys_rst,
  input  wire stm_pkg::stm_wb_req_t i_wb_req,
  output logic [31:0]             o_wb_dat,
  output logic                    o_wb_ack,
  input  wire logic               i_external_count_input,
  input  wire logic               i_time_base_clock,
  input  wire logic               i_capture_in,
  output logic                    o_timer_out,
  output logic                    o_match_a_flag,
  output logic                    o_match_p_flag
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  stm_pkg::stm_clk_ctrl_t  clk_ctrl_q;
  stm_pkg::stm_mode_ctrl_t mode_ctrl_q;
  logic [15:0]             count_q;
  logic [15:0]             cmp_a_q;
  logic [7:0]              cmp_p_q;
  logic [7:0]              lo_buf_q;
  logic                    on_prev_q;
  logic [5:0]              div_q;
  logic                    out_q;
  logic                    pin_q;
  logic                    flag_a_q;
  logic                    flag_p_q;
  logic                    ack_q;
  logic [31:0]             rdata_q;
  logic [2:0]              sync1_q;
  logic [2:0]              sync2_q;
  logic [2:0]              sync3_q;
  logic [2:0]              lvl_q;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  // One compare shape for every strobe keeps the address map in one place
  function automatic logic adr_is(input logic [7:0] adr, input logic [7:0] ofs);
    adr_is = (adr == ofs);
  endfunction

  // Writes land at the ack edge; read side effects fire once, at the request edge
  wire       bus_req   = i_wb_req.cyc & i_wb_req.stb;
  wire       wr_fire   = bus_req & i_wb_req.we & ack_q & i_wb_req.sel[0];
  wire       rd_start  = bus_req & ~i_wb_req.we & ~ack_q;
  wire [7:0] wr_byte   = i_wb_req.dat[7:0];
  wire       wr_clk    = wr_fire & adr_is(i_wb_req.adr, stm_pkg::STM_OFS_CLK_CTRL);
  wire       wr_mode   = wr_fire & adr_is(i_wb_req.adr, stm_pkg::STM_OFS_MODE_CTRL);
  wire       wr_a_lo   = wr_fire & adr_is(i_wb_req.adr, stm_pkg::STM_OFS_CMPA_LO);
  wire       wr_a_hi   = wr_fire & adr_is(i_wb_req.adr, stm_pkg::STM_OFS_CMPA_HI);
  wire       wr_p      = wr_fire & adr_is(i_wb_req.adr, stm_pkg::STM_OFS_CMPP);
  wire       rd_cnt_hi = rd_start & adr_is(i_wb_req.adr, stm_pkg::STM_OFS_COUNT_HI);
  wire       rd_a_hi   = rd_start & adr_is(i_wb_req.adr, stm_pkg::STM_OFS_CMPA_HI);

  // Low-byte reads return the shared buffer, not the live value
  logic [7:0] rd_byte;
  always_comb begin
    case (i_wb_req.adr)
      stm_pkg::STM_OFS_CLK_CTRL:  rd_byte = clk_ctrl_q & stm_pkg::STM_CLK_CTRL_MASK;
      stm_pkg::STM_OFS_MODE_CTRL: rd_byte = mode_ctrl_q;
      stm_pkg::STM_OFS_COUNT_LO:  rd_byte = lo_buf_q;
      stm_pkg::STM_OFS_COUNT_HI:  rd_byte = count_q[15:8];
      stm_pkg::STM_OFS_CMPA_LO:   rd_byte = lo_buf_q;
      stm_pkg::STM_OFS_CMPA_HI:   rd_byte = cmp_a_q[15:8];
      stm_pkg::STM_OFS_CMPP:      rd_byte = cmp_p_q;
      default:                    rd_byte = stm_pkg::STM_RST_BYTE;
    endcase
  end

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // A pin level counts once stages two and three agree; stage one feeds
  // stage two only, so a metastable sample never reaches the edge logic.
  wire [2:0] pin_raw   = {i_capture_in, i_time_base_clock, i_external_count_input};
  wire [2:0] pin_agree = ~(sync2_q ^ sync3_q);
  wire [2:0] pin_rise  = pin_agree & sync3_q & ~lvl_q;
  wire [2:0] pin_fall  = pin_agree & ~sync3_q & lvl_q;

  // ----------------------------------------------------------------
  // Count tick selection
  // ----------------------------------------------------------------
  // The high clock is taken equal to the system clock; no second domain.
  wire div4_tick  = (div_q[1:0] == stm_pkg::STM_DIV4_MASK[1:0]);
  wire div16_tick = (div_q[3:0] == stm_pkg::STM_DIV16_MASK[3:0]);
  wire div64_tick = (div_q == stm_pkg::STM_DIV64_MASK);

  // Both time-base codes share one pin; there is no second time-base clock
  logic src_tick;
  always_comb begin
    case (clk_ctrl_q.clock_source_select)
      stm_pkg::STM_SRC_SYS_DIV4: src_tick = div4_tick;
      stm_pkg::STM_SRC_SYS:      src_tick = 1'b1;
      stm_pkg::STM_SRC_HI_DIV16: src_tick = div16_tick;
      stm_pkg::STM_SRC_HI_DIV64: src_tick = div64_tick;
      stm_pkg::STM_SRC_TBC_A:    src_tick = pin_rise[stm_pkg::STM_PIN_TBC];
      stm_pkg::STM_SRC_TBC_B:    src_tick = pin_rise[stm_pkg::STM_PIN_TBC];
      stm_pkg::STM_SRC_EXT_RISE: src_tick = pin_rise[stm_pkg::STM_PIN_EXT];
      stm_pkg::STM_SRC_EXT_FALL: src_tick = pin_fall[stm_pkg::STM_PIN_EXT];
      default:                   src_tick = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Counter and comparators
  // ----------------------------------------------------------------
  stm_pkg::stm_mode_t mode;
  assign mode = mode_ctrl_q.operating_mode_select;

  wire        on_rise  = clk_ctrl_q.counter_on & ~on_prev_q;
  wire        run_tick = clk_ctrl_q.counter_on & ~clk_ctrl_q.pause_control & src_tick;
  wire [16:0] inc      = {1'b0, count_q} + 17'h00001;
  wire        p_is_ovf = (cmp_p_q == stm_pkg::STM_CMPP_OVF);
  // Matches are judged on the value the counter is about to reach
  wire hit_p = p_is_ovf ? inc[16]
                        : ((inc[15:8] == cmp_p_q) && (inc[7:0] == 8'h00));
  wire hit_a = (inc[15:0] == cmp_a_q);
  wire ev_a  = run_tick & hit_a;
  wire ev_p  = run_tick & hit_p;

  wire is_cmp_like = (mode == stm_pkg::STM_MODE_COMPARE) || (mode == stm_pkg::STM_MODE_TIMER);
  wire clr_sel_a   = mode_ctrl_q.clear_source_select;

  // Capture mode clears on P only; clear select has no say outside compare
  // and timer modes
  logic clear_ev;
  always_comb begin
    case (mode)
      stm_pkg::STM_MODE_PWM:     clear_ev = mode_ctrl_q.period_duty_swap ? ev_a : ev_p;
      stm_pkg::STM_MODE_CAPTURE: clear_ev = ev_p;
      default:                   clear_ev = clr_sel_a ? ev_a : ev_p;
    endcase
  end

  // Counter has no software load path; the bus only reaches it through on_rise
  wire [15:0] count_d = on_rise  ? stm_pkg::STM_RST_WORD :
                        run_tick ? (clear_ev ? stm_pkg::STM_RST_WORD : inc[15:0]) :
                        count_q;

  // ----------------------------------------------------------------
  // Capture
  // ----------------------------------------------------------------
  // The capture pin passes the same three stages, so the copied count lags
  // the pin by three or four cycles
  logic cap_edge;
  always_comb begin
    case (mode_ctrl_q.output_function_select)
      stm_pkg::STM_CAP_RISE: cap_edge = pin_rise[stm_pkg::STM_PIN_CAP];
      stm_pkg::STM_CAP_FALL: cap_edge = pin_fall[stm_pkg::STM_PIN_CAP];
      stm_pkg::STM_CAP_BOTH: cap_edge = pin_rise[stm_pkg::STM_PIN_CAP] |
                                        pin_fall[stm_pkg::STM_PIN_CAP];
      default:               cap_edge = 1'b0;
    endcase
  end
  wire cap_ev = (mode == stm_pkg::STM_MODE_CAPTURE) & clk_ctrl_q.counter_on & cap_edge;

  // ----------------------------------------------------------------
  // Flags
  // ----------------------------------------------------------------
  // Pulses only; an interrupt controller outside must latch them
  wire flag_a_d = (mode == stm_pkg::STM_MODE_CAPTURE) ? cap_ev : ev_a;
  wire flag_p_d = ev_p & ~(is_cmp_like & clr_sel_a);

  // ----------------------------------------------------------------
  // Output pin
  // ----------------------------------------------------------------
  wire        init_lvl = mode_ctrl_q.output_initial_level;
  // Duty as a 17-bit span so a P duty of zero means the full 65536 count
  wire [16:0] duty = mode_ctrl_q.period_duty_swap ?
                     (p_is_ovf ? stm_pkg::STM_FULL_SPAN : {1'b0, cmp_p_q, 8'h00}) :
                     {1'b0, cmp_a_q};
  // Duty at or above the period keeps the output active all the time
  wire        pwm_lvl = ({1'b0, count_q} < duty) ? init_lvl : ~init_lvl;

  logic cmp_next;
  always_comb begin
    case (mode_ctrl_q.output_function_select)
      stm_pkg::STM_IO_LOW:    cmp_next = 1'b0;
      stm_pkg::STM_IO_HIGH:   cmp_next = 1'b1;
      stm_pkg::STM_IO_TOGGLE: cmp_next = ~out_q;
      default:                cmp_next = out_q;
    endcase
  end

  logic pwm_next;
  always_comb begin
    case (mode_ctrl_q.output_function_select)
      stm_pkg::STM_IO_ACT:    pwm_next = init_lvl;
      stm_pkg::STM_IO_PWM:    pwm_next = pwm_lvl;
      // Single-pulse waveform is not built here; its pin rests inactive
      stm_pkg::STM_IO_SINGLE: pwm_next = ~init_lvl;
      default:                pwm_next = ~init_lvl;
    endcase
  end

  logic out_d;
  always_comb begin
    case (mode)
      stm_pkg::STM_MODE_COMPARE: out_d = on_rise ? init_lvl :
                                         (ev_a ? cmp_next : out_q);
      stm_pkg::STM_MODE_PWM:     out_d = pwm_next;
      default:                   out_d = out_q;
    endcase
  end
  // Timer/counter mode leaves the pin unused, so it rests low
  wire pin_d = (mode == stm_pkg::STM_MODE_TIMER) ? 1'b0 :
               (out_d ^ mode_ctrl_q.output_invert);

  // ----------------------------------------------------------------
  // Sequential logic
  // ----------------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    sync1_q <= pin_raw;
    sync2_q <= sync1_q;
    sync3_q <= sync2_q;
    if (i_sys_rst) begin
      lvl_q <= 3'h0;
    end else begin
      lvl_q <= (pin_agree & sync3_q) | (~pin_agree & lvl_q);
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      ack_q   <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else begin
      // A held request is answered every other cycle, never twice in a row
      ack_q <= bus_req & ~ack_q;
      // Read data is taken at the request edge so it stands with ack
      if (rd_start) begin
        rdata_q <= {24'h000000, rd_byte};
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      clk_ctrl_q  <= stm_pkg::STM_RST_BYTE;
      mode_ctrl_q <= stm_pkg::STM_RST_BYTE;
      cmp_p_q     <= stm_pkg::STM_RST_BYTE;
    end else begin
      if (wr_clk) begin
        clk_ctrl_q <= wr_byte & stm_pkg::STM_CLK_CTRL_MASK;
      end
      if (wr_mode) begin
        mode_ctrl_q <= wr_byte;
      end
      if (wr_p) begin
        cmp_p_q <= wr_byte;
      end
    end
  end

  // Capture wins over a bus write to compare A in the same cycle
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      cmp_a_q  <= stm_pkg::STM_RST_WORD;
      lo_buf_q <= stm_pkg::STM_RST_BYTE;
    end else begin
      if (cap_ev) begin
        cmp_a_q <= count_q;
      end else if (wr_a_hi) begin
        cmp_a_q <= {wr_byte, lo_buf_q};
      end
      if (wr_a_lo) begin
        lo_buf_q <= wr_byte;
      end else if (rd_cnt_hi) begin
        lo_buf_q <= count_q[7:0];
      end else if (rd_a_hi) begin
        lo_buf_q <= cmp_a_q[7:0];
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      count_q   <= stm_pkg::STM_RST_WORD;
      on_prev_q <= 1'b0;
      div_q     <= 6'h00;
      out_q     <= 1'b0;
      pin_q     <= 1'b0;
      flag_a_q  <= 1'b0;
      flag_p_q  <= 1'b0;
    end else begin
      count_q   <= count_d;
      on_prev_q <= clk_ctrl_q.counter_on;
      // Prescaler runs free; software cannot align its phase to the on bit
      div_q     <= div_q + 6'h01;
      out_q     <= out_d;
      pin_q     <= pin_d;
      flag_a_q  <= flag_a_d;
      flag_p_q  <= flag_p_d;
    end
  end

  assign o_wb_ack       = ack_q;
  assign o_wb_dat       = rdata_q;
  assign o_timer_out    = pin_q;
  assign o_match_a_flag = flag_a_q;
  assign o_match_p_flag = flag_p_q;

endmodule

// file: verification/stm_timer16_assertions.sv
// Concurrent checks on the ports of the 16-bit standard timer.
// Assumes single-beat Wishbone access; control registers are shadowed from bus writes.
`timescale 1ns/1ps
module stm_timer16_chk (
  input wire logic                 i_mclk,
  input wire logic                 i_sys_rst,
  input wire stm_pkg::stm_wb_req_t i_wb_req,
  input wire logic [31:0]          o_wb_dat,
  input wire logic                 o_wb_ack,
  input wire logic                 o_timer_out,
  input wire logic                 o_match_a_flag,
  input wire logic                 o_match_p_flag
);
  // --------
  // Shadows
  // --------
  stm_pkg::stm_clk_ctrl_t  clk_q;
  stm_pkg::stm_mode_ctrl_t mode_q;
  wire wr_ack = o_wb_ack && i_wb_req.cyc && i_wb_req.stb && i_wb_req.we && i_wb_req.sel[0];
  wire rd_ack = o_wb_ack && !i_wb_req.we;
  wire ad_clk = i_wb_req.adr == stm_pkg::STM_OFS_CLK_CTRL;
  wire ad_md  = i_wb_req.adr == stm_pkg::STM_OFS_MODE_CTRL;
  wire cmp_md = mode_q.operating_mode_select == stm_pkg::STM_MODE_COMPARE;
  wire tmr_md = mode_q.operating_mode_select == stm_pkg::STM_MODE_TIMER;
  wire cap_md = mode_q.operating_mode_select == stm_pkg::STM_MODE_CAPTURE;
  wire out_lv = mode_q.output_initial_level ^ mode_q.output_invert;
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      clk_q  <= '0;
      mode_q <= '0;
    end else begin
      if (wr_ack && ad_clk) clk_q <= i_wb_req.dat[7:0];
      if (wr_ack && ad_md) mode_q <= i_wb_req.dat[7:0];
    end
  end
  // -----------
  // Properties
  // -----------
  // Stability terms skip the cycle after a control write, where an old tick may still land
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_sys_rst);
  property p_ack_one; o_wb_ack |=> !o_wb_ack; endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack held");
  property p_ack_lat; i_wb_req.cyc && i_wb_req.stb && !o_wb_ack |=> o_wb_ack; endproperty
  a_ack_lat: assert property (p_ack_lat) else $error("ack late");
  property p_p_gap; o_match_p_flag |=> !o_match_p_flag [*8]; endproperty
  a_p_gap: assert property (p_p_gap) else $error("p flags too close");
  property p_no_pf;
    (cmp_md || tmr_md) && mode_q.clear_source_select && $stable(mode_q) |-> !o_match_p_flag;
  endproperty
  a_no_pf: assert property (p_no_pf) else $error("p flag with clear on a");
  property p_tmr_pin; tmr_md && $stable(mode_q) |-> !o_timer_out; endproperty
  a_tmr_pin: assert property (p_tmr_pin) else $error("pin moved in timer mode");
  property p_on_lvl; $rose(clk_q.counter_on) && cmp_md |-> ##[0:3] o_timer_out == out_lv; endproperty
  a_on_lvl: assert property (p_on_lvl) else $error("pin not at initial level");
  property p_pause;
    clk_q.pause_control && $stable(clk_q) && !cap_md |-> !o_match_a_flag && !o_match_p_flag;
  endproperty
  a_pause: assert property (p_pause) else $error("match while paused");
  property p_off;
    !clk_q.counter_on && $stable(clk_q) && !cap_md |-> !(o_match_a_flag || o_match_p_flag);
  endproperty
  a_off: assert property (p_off) else $error("match while off");
  property p_rd_clk;
    rd_ack && ad_clk |-> o_wb_dat == {24'h0, clk_q & stm_pkg::STM_CLK_CTRL_MASK};
  endproperty
  a_rd_clk: assert property (p_rd_clk) else $error("clock control readback");
  property p_rd_md; rd_ack && ad_md |-> o_wb_dat == {24'h0, mode_q}; endproperty
  a_rd_md: assert property (p_rd_md) else $error("mode control readback");
  c_pflag: cover property (o_match_p_flag);
  c_aflag: cover property (o_match_a_flag && cmp_md);
  c_pause: cover property (clk_q.pause_control && clk_q.counter_on);
endmodule

bind stm_timer16 stm_timer16_chk u_chk (
  .i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_wb_req(i_wb_req), .o_wb_dat(o_wb_dat),
  .o_wb_ack(o_wb_ack), .o_timer_out(o_timer_out), .o_match_a_flag(o_match_a_flag),
  .o_match_p_flag(o_match_p_flag)
);

// file: verification/stm_pin_model.sv
// Pin-side partner: drives the external count and time-base pins.
// Assumes whole frames on i_run; the pin idles low between frames.
`timescale 1ns/1ps
module stm_pin_model (
  input  wire logic i_mclk,
  input  wire logic i_run,
  output logic      o_ext
);
  logic [2:0] cnt_q = 3'h0;
  initial o_ext = 1'h0;
  // Eight cycles a level keeps each edge well clear of the 3-FF synchroniser
  always @(posedge i_mclk) begin
    if (!i_run) begin
      cnt_q <= 3'h0;
      o_ext <= 1'h0;
    end else begin
      cnt_q <= cnt_q + 3'h1;
      if (cnt_q == 3'h7) o_ext <= !o_ext;
    end
  end
endmodule

// file: verification/tb_top.sv
// Self-checking bench for the 16-bit standard timer.
// Assumes the register map and one-cycle ack of the hand-over contract.
`timescale 1ns/1ps
module tb_top;
  logic                 i_mclk;
  logic                 i_sys_rst;
  stm_pkg::stm_wb_req_t req;
  logic [31:0]          rdat;
  logic                 ack;
  logic                 ext;
  logic                 run;
  logic                 cap;
  logic                 tout;
  logic                 fla;
  logic                 flp;
  int                   mismatches;
  int                   n_tests;
  int                   ncyc;

  stm_timer16 uut (
    .i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_wb_req(req), .o_wb_dat(rdat), .o_wb_ack(ack),
    .i_external_count_input(ext), .i_time_base_clock(ext), .i_capture_in(cap),
    .o_timer_out(tout), .o_match_a_flag(fla), .o_match_p_flag(flp)
  );
  stm_pin_model u_pin (.i_mclk(i_mclk), .i_run(run), .o_ext(ext));

  initial begin
    i_mclk = 1'h0;
    forever #2 i_mclk = !i_mclk;
  end
  // Whole run needs about 3000 cycles
  always @(posedge i_mclk) begin
    ncyc++;
    if (ncyc == 20000) begin
      mismatches++;
      print_verdict();
    end
  end
  // --------
  // Helpers
  // --------
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [16:0] e, input logic [16:0] g);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  // Request held until ack is sampled; released only on that edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    @(posedge i_mclk);
    req <= '{1'h1, 1'h1, w, a, 4'hF, {24'h0, d}};
    @(posedge i_mclk);
    while (ack !== 1'h1) @(posedge i_mclk);
    q = rdat[7:0];
    req <= '0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(1'h1, a, d, q);
  endtask
  task automatic rdc(input string nm, input logic [7:0] a, input logic [7:0] e);
    logic [7:0] q;
    bus(1'h0, a, 8'h00, q);
    chk(nm, {9'h0, e}, {9'h0, q});
  endtask
  task automatic rcnt(output logic [15:0] c);
    bus(1'h0, 8'h0C, 8'h00, c[15:8]);
    bus(1'h0, 8'h08, 8'h00, c[7:0]);
  endtask
  // ----------
  // Scenarios
  // ----------
  task automatic t_regs();
    for (int a = 0; a < 32; a += 4) rdc("reset value", 8'(a), 8'h00);
    wr(8'h00, 8'hF7);
    rdc("clk ctrl", 8'h00, 8'hF0);
    wr(8'h00, 8'h00);
    wr(8'h04, 8'h5A);
    rdc("mode ctrl", 8'h04, 8'h5A);
    wr(8'h18, 8'hA5);
    rdc("cmp p", 8'h18, 8'hA5);
    wr(8'h10, 8'h34);
    wr(8'h14, 8'h12);
    rdc("cmp a high", 8'h14, 8'h12);
    rdc("cmp a low", 8'h10, 8'h34);
    wr(8'h1C, 8'hFF);
    rdc("unmapped", 8'h1C, 8'h00);
  endtask
  task automatic t_count();
    logic [15:0] c1;
    logic [15:0] c2;
    wr(8'h04, 8'hC0);
    wr(8'h18, 8'h00);
    wr(8'h00, 8'h18);
    wr(8'h00, 8'h98);
    rcnt(c1);
    rcnt(c2);
    chk("paused", c1, c2);
    wr(8'h00, 8'h18);
    rcnt(c2);
    chk("resumed", 1'h1, c2 > c1 && c2 < c1 + 16'h10);
    wr(8'h00, 8'h10);
    rcnt(c1);
    wr(8'h08, 8'hFF);
    wr(8'h0C, 8'hFF);
    rcnt(c2);
    chk("held", c1, c2);
    wr(8'h00, 8'h18);
    rcnt(c2);
    chk("cleared", 1'h1, c2 < 16'h10);
  endtask
  task automatic t_cmp();
    logic [7:0] md [7] = '{8'h01, 8'h11, 8'h21, 8'h31, 8'h29, 8'h19, 8'h3D};
    logic       ex [7] = '{1'h0, 1'h0, 1'h1, 1'h1, 1'h1, 1'h0, 1'h1};
    int         k;
    wr(8'h10, 8'h03);
    wr(8'h14, 8'h00);
    for (int i = 0; i < 7; i++) begin
      wr(8'h00, 8'h10);
      wr(8'h04, md[i]);
      wr(8'h00, 8'h18);
      while (fla !== 1'h1) @(posedge i_mclk);
      #1;
      chk("pin after match", ex[i], tout);
      k = 0;
      do begin
        @(posedge i_mclk);
        k++;
      end while (fla !== 1'h1);
      chk("a clear period", 17'h3, k);
    end
  endtask
  task automatic t_pflag();
    int k;
    wr(8'h00, 8'h10);
    wr(8'h04, 8'hC0);
    wr(8'h18, 8'h01);
    wr(8'h00, 8'h18);
    while (flp !== 1'h1) @(posedge i_mclk);
    k = 0;
    do begin
      @(posedge i_mclk);
      k++;
    end while (flp !== 1'h1);
    chk("p clear period", 17'h100, k);
  endtask
  task automatic t_src();
    logic [15:0] c;
    logic [15:0] e;
    int          sh [4] = '{2, 0, 4, 6};
    wr(8'h00, 8'h10);
    wr(8'h18, 8'h00);
    for (int s = 0; s < 8; s++) begin
      wr(8'h00, {1'h0, 3'(s), 4'h8});
      if (s > 3) run <= 1'h1;
      repeat (80) @(posedge i_mclk);
      run <= 1'h0;
      repeat (8) @(posedge i_mclk);
      wr(8'h00, {1'h0, 3'(s), 4'h0});
      rcnt(c);
      e = 16'h5B >> sh[s % 4];
      if (s > 3)
        chk("pin ticks", 17'h5, c);
      else
        chk("sys ticks", 1'h1, c + 16'h2 >= e && c <= e + 16'h2);
    end
  endtask
  task automatic t_pwm();
    logic [7:0] md [5] = '{8'h88, 8'h98, 8'hA8, 8'hAA, 8'hAC};
    logic [8:0] ex [5] = '{9'h000, 9'h100, 9'h080, 9'h100, 9'h080};
    int         h;
    wr(8'h10, 8'h80);
    wr(8'h14, 8'h00);
    wr(8'h18, 8'h01);
    for (int i = 0; i < 5; i++) begin
      wr(8'h04, md[i]);
      wr(8'h00, 8'h18);
      repeat (8) @(posedge i_mclk);
      h = 0;
      repeat (256) begin
        @(posedge i_mclk);
        h += tout;
      end
      chk("pwm active cycles", ex[i], h);
      wr(8'h00, 8'h10);
    end
  endtask

  task automatic t_cap();
    logic [15:0] c1;
    logic [15:0] c2;
    logic [15:0] ca;
    int          k;
    wr(8'h00, 8'h10);
    wr(8'h04, 8'h40);
    wr(8'h00, 8'h18);
    rcnt(c1);
    cap <= 1'h1;
    k = 0;
    while (fla !== 1'h1 && k < 16) begin
      @(posedge i_mclk);
      k++;
    end
    chk("capture flag", 1'h1, fla);
    rcnt(c2);
    bus(1'h0, 8'h14, 8'h00, ca[15:8]);
    bus(1'h0, 8'h10, 8'h00, ca[7:0]);
    chk("capture value", 1'h1, ca > c1 && ca < c2);
    cap <= 1'h0;
    wr(8'h00, 8'h10);
    wr(8'h04, 8'h70);
    wr(8'h00, 8'h18);
    cap <= 1'h1;
    k = 0;
    repeat (12) begin
      @(posedge i_mclk);
      if (fla === 1'h1) k++;
    end
    chk("capture disabled", 17'h0, k);
    cap <= 1'h0;
    wr(8'h00, 8'h10);
    repeat (8) @(posedge i_mclk);
  endtask

  initial begin
    i_sys_rst = 1'h1;
    req = '0;
    run = 1'h0;
    cap = 1'h0;
    repeat (4) @(posedge i_mclk);
    i_sys_rst <= 1'h0;
    t_regs();
    t_count();
    t_cmp();
    t_pflag();
    t_src();
    t_pwm();
    t_cap();
    print_verdict();
  end
endmodule
